// *** logic/das_pkg.sv ***
// Constants and carrier types for the disk adapter status select block.
// Assumes the spindle controllers and the ECC checker run on the adapter clock.
package das_pkg;

    localparam int SPINDLES = 5;

    // Function codes as issued by the channel
    localparam logic [4:0] FN_CLEAR = 5'h00;
    localparam logic [4:0] FN_RD_STAT0 = 5'h0a;
    localparam logic [4:0] FN_SPD_SEL = 5'h0f;

    // Parcel select codes in accumulator bits 2..0
    localparam logic [2:0] SEL_INT = 3'h0;
    localparam logic [2:0] SEL_ECC = 3'h1;
    localparam logic [2:0] SEL_XFER = 3'h2;
    localparam logic [2:0] SEL_CBUS = 3'h3;
    localparam logic [2:0] SEL_BUSY = 3'h4;
    localparam logic [2:0] SEL_DONE = 3'h5;
    localparam logic [2:0] SEL_PEND = 3'h6;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // Spindle-select accumulator layout
    localparam int SELM_BIT = 0;
    localparam int SPD_MASK_LO = 8;
    localparam logic [SPINDLES-1:0] SEL_MASK_RST = 5'h1f;

    // Per-spindle error vector: interrupt bits 0..3 then 8..10
    localparam int E_PAR = 0;
    localparam int E_SEQ = 1;
    localparam int E_LOST = 2;
    localparam int E_END = 3;
    localparam int E_IDCMP = 4;
    localparam int E_ECC = 5;
    localparam int E_IDERR = 6;
    localparam int ERR_W = 7;
    localparam int IDF_W = 5;

    // Interrupt parcel field positions
    localparam int INT_VOLT_LO = 4;
    localparam int INT_SECDED = 6;
    localparam int INT_NIB = 7;
    localparam int INT_HI_ERR_LO = 8;
    localparam int INT_IDF_LO = 11;

    // ECC parcel field positions
    localparam int ECC_SBE_LO = 8;
    localparam int ECC_DBE_LO = 12;
    localparam logic [3:0] CNT_MAX = 4'hf;

    typedef struct packed {
        logic valid;
        logic [4:0] code;
        logic [15:0] acc;
    } das_fn_t;

    typedef struct packed {
        logic fn_start;
        logic fn_end;
        logic resp_par_err;
        logic rd_par_err;
        logic bad_init;
        logic sel_tmo;
        logic wr_late;
        logic rd_late;
        logic bus_seq_done;
        logic [7:0] end_status;
        logic end_par_err;
        logic id_cmp_err;
        logic ecc_err;
        logic id_err;
        logic id_cmp_done;
        logic [IDF_W-1:0] id_flags;
        logic pend_set;
        logic pend_clr;
        logic [7:0] cbus;
    } das_spd_evt_t;

    typedef struct packed {
        logic chk;
        logic sbe;
        logic dbe;
        logic [7:0] syndrome;
    } das_ecc_evt_t;

    typedef struct packed {
        logic [SPINDLES-1:0][ERR_W-1:0] err;
        logic [SPINDLES-1:0][IDF_W-1:0] idf;
        logic [SPINDLES-1:0] sel;
        logic [SPINDLES-1:0] busy;
        logic [SPINDLES-1:0] done;
        logic [SPINDLES-1:0] pend;
        logic [7:0] syn;
        logic [3:0] sbe;
        logic [3:0] dbe;
        logic nib;
        logic [1:0] v1;
        logic [1:0] v2;
        logic [15:0] acc_out;
        logic acc_valid;
    } das_state_t;

endpackage : das_pkg

// *** logic/das_status_select.sv ***
// Status-read and error-flag logic of a multi-spindle disk channel adapter.
// Assumes function issue, spindle events and ECC events arrive on clk;
// only the two supply pins come from outside and are synchronised.
//
// Function
// - Read-status returns one parcel, chosen by accumulator bits 2..0 at issue.
// - Codes 0..6 pick interrupt, ECC, count, bus, busy, done, pending; 7 reads zero.
// - ECC parcel: syndrome 7..0, single count 11..8, double count 15..12.
// - Busy, done and pending parcels show spindles 0..4 in bits 0..4.
// - Bus parcel bits 0..7 are the eight bus lines ORed over selected spindles.
// - Clear resets interrupt 0..3, 6..10, ECC 8..15, busy, done, pending.
// - A function ending in error sets both busy and done.
// - Queued functions still start after an errored function.
// - Interrupt bits 0..3 and 8..15 are ORed over selected spindles.
// - Bits 11..15 copy last ID compare flags; 12..14 cause busy/done.
// - Single-bit ECC errors never hold busy after completion.
// - Bits 0..3, 8, 9, 10 keep the erring spindle busy after completion.
// - Bit 0 sets on spindle response or read data parity error.
// - Bit 1 sets on bad initial interface state or select timeout.
// - Bit 2 sets when write or read data misses the spindle buffer timing.
// - Bit 3 sets after bus sequence on bad ending status bits.
// - Bits 4 and 5 are supply status only, no action.
// - Bit 6 is single count nonzero OR double count nonzero.
// - Bit 7 sets on any nibble parity error.
// - Bit 10 sets when an ID error stops a read or write.
// - ECC error alone means error after data field or on read ID.
`timescale 1ns/1ps

module das_status_select (
    input wire logic clk,
    input wire logic arst_n,
    input wire das_pkg::das_fn_t fn,
    input wire das_pkg::das_spd_evt_t [das_pkg::SPINDLES-1:0] spd_evt,
    input wire das_pkg::das_ecc_evt_t ecc_evt,
    input wire logic nib_par_err,
    input wire logic [15:0] xfer_count,
    input wire logic [1:0] supply_pins,
    output logic [15:0] acc_out,
    output logic acc_valid,
    output logic [das_pkg::SPINDLES-1:0] spd_busy,
    output logic [das_pkg::SPINDLES-1:0] spd_done
);

    das_pkg::das_state_t st_ff;
    das_pkg::das_state_t nxt_st;

    logic clr;
    logic rd;
    logic [das_pkg::SPINDLES-1:0][7:0] pad_err;
    logic [das_pkg::SPINDLES-1:0][7:0] pad_idf;
    logic [das_pkg::SPINDLES-1:0][7:0] cbus_v;
    logic [7:0] err_or;
    logic [7:0] idf_or;
    logic [7:0] cbus_or;
    logic [15:0] parcel;

    // OR of per-spindle bytes over the selected set
    function automatic logic [7:0] or_sel(
        input logic [das_pkg::SPINDLES-1:0][7:0] v,
        input logic [das_pkg::SPINDLES-1:0] m
    );
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < das_pkg::SPINDLES; i++) begin
            if (m[i]) begin
                r = r | v[i];
            end
        end
        return r;
    endfunction : or_sel

    // Errors that keep a spindle busy once its function ends
    function automatic logic hold_busy(
        input logic [das_pkg::ERR_W-1:0] e,
        input logic [das_pkg::IDF_W-1:0] f
    );
        // Single-bit corrections never reach e, so they cannot hold busy
        return (|e) | (|f[3:1]);
    endfunction : hold_busy

    assign clr = fn.valid && (fn.code == das_pkg::FN_CLEAR);
    assign rd = fn.valid && (fn.code == das_pkg::FN_RD_STAT0);

    always_comb begin
        for (int i = 0; i < das_pkg::SPINDLES; i++) begin
            pad_err[i] = {1'b0, st_ff.err[i]};
            pad_idf[i] = {3'h0, st_ff.idf[i]};
            cbus_v[i] = spd_evt[i].cbus;
        end
        err_or = or_sel(pad_err, st_ff.sel);
        idf_or = or_sel(pad_idf, st_ff.sel);
        cbus_or = or_sel(cbus_v, st_ff.sel);
        parcel = 16'h0000;
        unique case (fn.acc[2:0])
            das_pkg::SEL_INT: begin
                parcel[3:0] = err_or[3:0];
                parcel[das_pkg::INT_VOLT_LO +: 2] = st_ff.v2;
                parcel[das_pkg::INT_SECDED] = (st_ff.sbe != 4'h0) || (st_ff.dbe != 4'h0);
                parcel[das_pkg::INT_NIB] = st_ff.nib;
                parcel[das_pkg::INT_HI_ERR_LO +: 3] = err_or[6:4];
                parcel[das_pkg::INT_IDF_LO +: das_pkg::IDF_W] = idf_or[4:0];
            end
            das_pkg::SEL_ECC: begin
                parcel[7:0] = st_ff.syn;
                parcel[das_pkg::ECC_SBE_LO +: 4] = st_ff.sbe;
                parcel[das_pkg::ECC_DBE_LO +: 4] = st_ff.dbe;
            end
            das_pkg::SEL_XFER: parcel = xfer_count;
            das_pkg::SEL_CBUS: parcel[7:0] = cbus_or;
            das_pkg::SEL_BUSY: parcel[das_pkg::SPINDLES-1:0] = st_ff.busy;
            das_pkg::SEL_DONE: parcel[das_pkg::SPINDLES-1:0] = st_ff.done;
            das_pkg::SEL_PEND: parcel[das_pkg::SPINDLES-1:0] = st_ff.pend;
            das_pkg::SEL_NONE: parcel = 16'h0000;
        endcase
    end

    always_comb begin
        das_pkg::das_spd_evt_t e;
        e = '0;
        nxt_st = st_ff;
        nxt_st.acc_valid = 1'b0;
        nxt_st.v1 = supply_pins;
        nxt_st.v2 = st_ff.v1;
        if (rd) begin
            // Select is taken from the accumulator of the issuing cycle
            nxt_st.acc_valid = 1'b1;
            nxt_st.acc_out = parcel;
        end
        if (fn.valid && fn.code == das_pkg::FN_SPD_SEL && fn.acc[das_pkg::SELM_BIT]) begin
            nxt_st.sel = fn.acc[das_pkg::SPD_MASK_LO +: das_pkg::SPINDLES];
        end
        // Clear is applied first so that same-cycle events still set
        if (clr) begin
            for (int i = 0; i < das_pkg::SPINDLES; i++) begin
                nxt_st.err[i] = '0;
            end
            nxt_st.nib = 1'b0;
            nxt_st.sbe = 4'h0;
            nxt_st.dbe = 4'h0;
            nxt_st.busy = '0;
            nxt_st.done = '0;
            nxt_st.pend = '0;
        end
        if (nib_par_err) begin
            nxt_st.nib = 1'b1;
        end
        if (ecc_evt.chk) begin
            nxt_st.syn = ecc_evt.syndrome;
            if (ecc_evt.sbe && nxt_st.sbe != das_pkg::CNT_MAX) begin
                nxt_st.sbe = nxt_st.sbe + 4'h1;
            end
            if (ecc_evt.dbe && nxt_st.dbe != das_pkg::CNT_MAX) begin
                nxt_st.dbe = nxt_st.dbe + 4'h1;
            end
        end
        for (int i = 0; i < das_pkg::SPINDLES; i++) begin
            e = spd_evt[i];
            if (e.resp_par_err || e.rd_par_err) begin
                nxt_st.err[i][das_pkg::E_PAR] = 1'b1;
            end
            if (e.bad_init || e.sel_tmo) begin
                nxt_st.err[i][das_pkg::E_SEQ] = 1'b1;
            end
            if (e.wr_late || e.rd_late) begin
                nxt_st.err[i][das_pkg::E_LOST] = 1'b1;
            end
            if (e.bus_seq_done && ((e.end_status[3:0] != 4'h0) || e.end_par_err || !e.end_status[7])) begin
                nxt_st.err[i][das_pkg::E_END] = 1'b1;
            end
            if (e.id_cmp_err) begin
                nxt_st.err[i][das_pkg::E_IDCMP] = 1'b1;
            end
            if (e.ecc_err) begin
                nxt_st.err[i][das_pkg::E_ECC] = 1'b1;
            end
            if (e.id_err) begin
                nxt_st.err[i][das_pkg::E_IDERR] = 1'b1;
            end
            if (e.id_cmp_done) begin
                nxt_st.idf[i] = e.id_flags;
            end
            if (e.pend_clr) begin
                nxt_st.pend[i] = 1'b0;
            end
            if (e.pend_set) begin
                nxt_st.pend[i] = 1'b1;
            end
            // A start is never refused for an earlier error
            if (e.fn_start) begin
                nxt_st.busy[i] = 1'b1;
                nxt_st.done[i] = 1'b0;
            end
            if (e.fn_end) begin
                nxt_st.done[i] = 1'b1;
                nxt_st.busy[i] = hold_busy(nxt_st.err[i], nxt_st.idf[i]);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
            st_ff.sel <= das_pkg::SEL_MASK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign acc_out = st_ff.acc_out;
    assign acc_valid = st_ff.acc_valid;
    assign spd_busy = st_ff.busy;
    assign spd_done = st_ff.done;

    // Checks on what the block drives

    rd_pulse_only_a: assert property (@(posedge clk) disable iff (!arst_n)
        !rd |=> !acc_valid)
        else $error("answer without read-status");

    busy_parcel_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_BUSY |=> acc_valid && acc_out == {11'h000, $past(st_ff.busy)})
        else $error("busy parcel wrong");

    ecc_parcel_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_ECC
        |=> acc_out == {$past(st_ff.dbe), $past(st_ff.sbe), $past(st_ff.syn)})
        else $error("ecc parcel wrong");

    code7_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_NONE |=> acc_out == 16'h0000)
        else $error("code 7 not zero");

    secded_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_INT
        |=> acc_out[6] == ($past(st_ff.sbe) != 4'h0 || $past(st_ff.dbe) != 4'h0))
        else $error("secded bit wrong");

    clear_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
        clr && !ecc_evt.chk && !nib_par_err && spd_evt[0] == '0
        |=> !st_ff.busy[0] && !st_ff.done[0] && st_ff.err[0] == '0 && st_ff.sbe == 4'h0 && !st_ff.nib)
        else $error("clear left flags");

    end_err_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[1].fn_end && (|st_ff.err[1] || spd_evt[1].resp_par_err) && !clr |=> spd_busy[1] && spd_done[1])
        else $error("errored end not busy and done");

    clean_end_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[0].fn_end && st_ff.err[0] == '0 && st_ff.idf[0][3:1] == 3'h0
        && (ecc_evt.sbe || st_ff.sbe != 4'h0) && !spd_evt[0].ecc_err && !spd_evt[0].id_cmp_done
        && !spd_evt[0].resp_par_err && !spd_evt[0].rd_par_err && !spd_evt[0].id_err
        && !spd_evt[0].bad_init && !spd_evt[0].sel_tmo && !spd_evt[0].wr_late && !spd_evt[0].rd_late
        && !spd_evt[0].bus_seq_done && !spd_evt[0].id_cmp_err
        |=> !spd_busy[0] && spd_done[0])
        else $error("single-bit error held busy");

    par_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[0].resp_par_err |=> st_ff.err[0][das_pkg::E_PAR] [*1] ##1 1'b1)
        else $error("parity bit not set");

    start_after_err_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[1].fn_start && !spd_evt[1].fn_end |=> spd_busy[1] && !spd_done[1])
        else $error("start refused");

    rd_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd |=> acc_valid)
        else $error("read not answered");

    held_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
        !rd |=> $stable(acc_out))
        else $error("answer changed without read");

    xfer_parcel_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_XFER |=> acc_out == $past(xfer_count))
        else $error("count parcel wrong");

    cbus_unused_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_CBUS |=> acc_out[15:8] == 8'h00)
        else $error("bus parcel high byte set");

    spd_unused_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2] && fn.acc[1:0] != 2'h3 |=> acc_out[15:5] == 11'h000)
        else $error("spindle parcel unused bits set");

    done_parcel_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_DONE |=> acc_out == {11'h000, $past(st_ff.done)})
        else $error("done parcel wrong");

    pend_parcel_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_PEND |=> acc_out == {11'h000, $past(st_ff.pend)})
        else $error("pending parcel wrong");

    int_volt_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_INT |=> acc_out[5:4] == $past(st_ff.v2))
        else $error("supply bits wrong");

    int_nib_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd && fn.acc[2:0] == das_pkg::SEL_INT |=> acc_out[7] == $past(st_ff.nib))
        else $error("nibble parity bit wrong");

    nib_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        nib_par_err |=> st_ff.nib)
        else $error("nibble parity not set");

    clear_count_a: assert property (@(posedge clk) disable iff (!arst_n)
        clr && !ecc_evt.chk |=> st_ff.sbe == 4'h0 && st_ff.dbe == 4'h0)
        else $error("clear left counts");

    clear_pend_a: assert property (@(posedge clk) disable iff (!arst_n)
        clr && !spd_evt[0].pend_set |=> !st_ff.pend[0])
        else $error("clear left pending");

    clear_keeps_idf_a: assert property (@(posedge clk) disable iff (!arst_n)
        clr && !spd_evt[3].id_cmp_done |=> st_ff.idf[3] == $past(st_ff.idf[3]))
        else $error("clear touched id flags");

    end_done_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[3].fn_end |=> spd_done[3])
        else $error("end without done");

    idf_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[4].fn_end && st_ff.idf[4][3:1] != 3'h0 && !spd_evt[4].id_cmp_done
        |=> spd_busy[4])
        else $error("id flaw flag did not hold busy");

    idf_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[3].id_cmp_done |=> st_ff.idf[3] == $past(spd_evt[3].id_flags))
        else $error("id flags not copied");

    seq_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[0].bad_init || spd_evt[0].sel_tmo |=> st_ff.err[0][das_pkg::E_SEQ])
        else $error("sequence bit not set");

    lost_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[0].wr_late || spd_evt[0].rd_late |=> st_ff.err[0][das_pkg::E_LOST])
        else $error("lost data bit not set");

    end_stat_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[3].bus_seq_done && !spd_evt[3].end_status[7] |=> st_ff.err[3][das_pkg::E_END])
        else $error("ending status bit not set");

    end_ok_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[3].bus_seq_done && spd_evt[3].end_status == 8'h80 && !spd_evt[3].end_par_err
        && !st_ff.err[3][das_pkg::E_END] |=> !st_ff.err[3][das_pkg::E_END])
        else $error("good ending status flagged");

    id_err_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[3].id_err |=> st_ff.err[3][das_pkg::E_IDERR])
        else $error("id error bit not set");

    ecc_err_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        spd_evt[3].ecc_err |=> st_ff.err[3][das_pkg::E_ECC])
        else $error("ecc error bit not set");

    sel_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        fn.valid && fn.code == das_pkg::FN_SPD_SEL && fn.acc[das_pkg::SELM_BIT]
        |=> st_ff.sel == $past(fn.acc[das_pkg::SPD_MASK_LO +: das_pkg::SPINDLES]))
        else $error("spindle mask not loaded");

    sel_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
        fn.valid && fn.code == das_pkg::FN_SPD_SEL && !fn.acc[das_pkg::SELM_BIT] |=> $stable(st_ff.sel))
        else $error("spindle mask changed with mode zero");

    sbe_count_a: assert property (@(posedge clk) disable iff (!arst_n)
        ecc_evt.chk && ecc_evt.sbe && !clr && st_ff.sbe != das_pkg::CNT_MAX
        |=> st_ff.sbe == $past(st_ff.sbe) + 4'h1)
        else $error("single count not stepped");

    syn_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        ecc_evt.chk |=> st_ff.syn == $past(ecc_evt.syndrome))
        else $error("syndrome not loaded");

endmodule : das_status_select

// *** sim/das_chan_model.sv ***
// Channel side model: turns a bench request into one function issue.
// Assumes the bench raises go for one cycle per function.
`timescale 1ns/1ps

module das_chan_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [4:0] go_code,
    input wire logic [15:0] go_acc,
    output das_pkg::das_fn_t fn
);
    // Accumulator travels with the code so the select bits are those at issue
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fn <= '0;
        end else begin
            fn.valid <= go;
            fn.code <= go_code;
            fn.acc <= go_acc;
        end
    end
endmodule : das_chan_model

// *** sim/das_status_select_bench.sv ***
// Self-checking bench for the status select block.
// Assumes the channel model in das_chan_model.sv; events are driven here.
`timescale 1ns/1ps

`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("BAD %0t %s", $time, m); end end

module das_status_select_bench;
    logic clk;
    logic arst_n;
    logic go;
    logic [4:0] go_code;
    logic [15:0] go_acc;
    das_pkg::das_fn_t fn;
    das_pkg::das_spd_evt_t [das_pkg::SPINDLES-1:0] spd_evt;
    das_pkg::das_ecc_evt_t ecc_evt;
    logic nib_par_err;
    logic [15:0] xfer_count;
    logic [1:0] supply_pins;
    logic [15:0] acc_out;
    logic acc_valid;
    logic [das_pkg::SPINDLES-1:0] spd_busy;
    logic [das_pkg::SPINDLES-1:0] spd_done;
    logic [7:0] cb [das_pkg::SPINDLES];
    int err_total;
    int num_checks;

    das_chan_model chan_u (.clk(clk), .arst_n(arst_n), .go(go), .go_code(go_code), .go_acc(go_acc), .fn(fn));

    das_status_select dut_u (
        .clk(clk), .arst_n(arst_n), .fn(fn), .spd_evt(spd_evt), .ecc_evt(ecc_evt),
        .nib_par_err(nib_par_err), .xfer_count(xfer_count), .supply_pins(supply_pins),
        .acc_out(acc_out), .acc_valid(acc_valid), .spd_busy(spd_busy), .spd_done(spd_done)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    task issue(input logic [4:0] c, input logic [15:0] a);
        @(posedge clk);
        go <= 1'b1;
        go_code <= c;
        go_acc <= a;
        @(posedge clk);
        go <= 1'b0;
    endtask : issue

    // Upper accumulator bits are set to show only bits 2..0 choose the parcel
    task rd(input logic [2:0] sel, input logic [15:0] exp);
        bit seen;
        seen = 0;
        issue(das_pkg::FN_RD_STAT0, {13'h1fff, sel});
        for (int i = 0; i < 6 && !seen; i++) begin
            @(posedge clk);
            #1;
            if (acc_valid === 1'b1) begin
                seen = 1;
            end
        end
        if (!seen) begin
            err_total++;
            $display("BAD %0t no answer", $time);
            final_report();
        end
        `CHK(acc_out, exp, "parcel value")
    endtask : rd

    // Kinds: 0 start, 1 clean end, 2 end with parity error, 3 pend set, 4 pend clear, 5..14: error sources, good ending status (7) or id flags
    task spd(input int s, input int k);
        das_pkg::das_spd_evt_t e;
        e = '0;
        e.cbus = cb[s];
        @(posedge clk);
        case (k)
            0: e.fn_start = 1'b1;
            1: e.fn_end = 1'b1;
            2: begin
                e.fn_end = 1'b1;
                e.resp_par_err = 1'b1;
            end
            3: e.pend_set = 1'b1;
            5: e.bad_init = 1'b1;
            6: e.wr_late = 1'b1;
            7: begin
                e.bus_seq_done = 1'b1;
                e.end_status = 8'h80;
            end
            8: e.bus_seq_done = 1'b1;
            9: begin
                e.id_cmp_err = 1'b1;
                e.id_err = 1'b1;
            end
            10: e.ecc_err = 1'b1;
            11: begin
                e.id_cmp_done = 1'b1;
                e.id_flags = 5'h11;
            end
            12: begin
                e.id_cmp_done = 1'b1;
                e.id_flags = 5'h04;
            end
            13: e.sel_tmo = 1'b1;
            14: e.rd_late = 1'b1;
            default: e.pend_clr = 1'b1;
        endcase
        spd_evt[s] <= e;
        @(posedge clk);
        e = '0;
        e.cbus = cb[s];
        spd_evt[s] <= e;
        #1;
    endtask : spd

    task ecc(input logic sbe, input logic dbe, input logic [7:0] syn);
        @(posedge clk);
        ecc_evt <= '{chk: 1'b1, sbe: sbe, dbe: dbe, syndrome: syn};
        @(posedge clk);
        ecc_evt <= '0;
    endtask : ecc

    task t_reset;
        `CHK(spd_busy, 5'h00, "busy after reset")
        rd(das_pkg::SEL_BUSY, 16'h0000);
        rd(das_pkg::SEL_DONE, 16'h0000);
        rd(das_pkg::SEL_INT, 16'h0020);
        $display("test reset done");
    endtask : t_reset

    task t_parcels;
        cb[2] = 8'ha5;
        @(posedge clk);
        spd_evt[2].cbus <= 8'ha5;
        rd(das_pkg::SEL_CBUS, 16'h00a5);
        rd(das_pkg::SEL_XFER, 16'hbeef);
        rd(das_pkg::SEL_NONE, 16'h0000);
        spd(4, 3);
        rd(das_pkg::SEL_PEND, 16'h0010);
        spd(4, 4);
        rd(das_pkg::SEL_PEND, 16'h0000);
        $display("test parcels done");
    endtask : t_parcels

    task t_err;
        spd(1, 0);
        `CHK(spd_busy, 5'h02, "busy on start")
        spd(1, 2);
        `CHK(spd_busy, 5'h02, "error holds busy")
        `CHK(spd_done, 5'h02, "error sets done")
        rd(das_pkg::SEL_INT, 16'h0021);
        // A following function must still run on another spindle
        spd(2, 0);
        `CHK(spd_busy, 5'h06, "queued start")
        spd(2, 1);
        `CHK(spd_busy, 5'h02, "clean end frees busy")
        rd(das_pkg::SEL_DONE, 16'h0006);
        $display("test error done");
    endtask : t_err

    task t_mask;
        issue(das_pkg::FN_SPD_SEL, 16'h1d01);
        rd(das_pkg::SEL_INT, 16'h0020);
        issue(das_pkg::FN_SPD_SEL, 16'h1f00);
        rd(das_pkg::SEL_INT, 16'h0020);
        issue(das_pkg::FN_SPD_SEL, 16'h1f01);
        rd(das_pkg::SEL_INT, 16'h0021);
        $display("test mask done");
    endtask : t_mask

    task t_clear;
        issue(das_pkg::FN_CLEAR, 16'h0000);
        rd(das_pkg::SEL_INT, 16'h0020);
        rd(das_pkg::SEL_BUSY, 16'h0000);
        `CHK(spd_done, 5'h00, "clear done")
        $display("test clear done");
    endtask : t_clear

    task t_ecc;
        spd(0, 0);
        ecc(1'b1, 1'b0, 8'h3c);
        spd(0, 1);
        `CHK(spd_busy, 5'h00, "single bit no hold")
        `CHK(spd_done, 5'h01, "done after end")
        rd(das_pkg::SEL_ECC, 16'h013c);
        rd(das_pkg::SEL_INT, 16'h0060);
        ecc(1'b0, 1'b1, 8'hc3);
        rd(das_pkg::SEL_ECC, 16'h11c3);
        @(posedge clk);
        nib_par_err <= 1'b1;
        @(posedge clk);
        nib_par_err <= 1'b0;
        rd(das_pkg::SEL_INT, 16'h00e0);
        issue(das_pkg::FN_CLEAR, 16'h0000);
        rd(das_pkg::SEL_ECC, 16'h00c3);
        rd(das_pkg::SEL_INT, 16'h0020);
        $display("test ecc done");
    endtask : t_ecc

    // Error sources one at a time (ID compare and ID error together), then id flags, which survive clear and may hold busy
    task t_flags;
        spd(3, 5);
        rd(das_pkg::SEL_INT, 16'h0022);
        spd(3, 6);
        rd(das_pkg::SEL_INT, 16'h0026);
        spd(3, 7);
        rd(das_pkg::SEL_INT, 16'h0026);
        spd(3, 8);
        rd(das_pkg::SEL_INT, 16'h002e);
        spd(3, 9);
        rd(das_pkg::SEL_INT, 16'h052e);
        spd(3, 10);
        rd(das_pkg::SEL_INT, 16'h072e);
        spd(3, 11);
        rd(das_pkg::SEL_INT, 16'h8f2e);
        issue(das_pkg::FN_CLEAR, 16'h0000);
        rd(das_pkg::SEL_INT, 16'h8820);
        spd(0, 13);
        rd(das_pkg::SEL_INT, 16'h8822);
        spd(0, 14);
        rd(das_pkg::SEL_INT, 16'h8826);
        spd(3, 0);
        spd(3, 1);
        `CHK(spd_busy, 5'h00, "informational flags held busy")
        spd(4, 12);
        spd(4, 0);
        spd(4, 1);
        `CHK(spd_busy, 5'h10, "id flaw flag not held busy")
        `CHK(spd_done, 5'h18, "flag end not done")
        rd(das_pkg::SEL_BUSY, 16'h0010);
        rd(das_pkg::SEL_INT, 16'ha826);
        issue(das_pkg::FN_SPD_SEL, 16'h0f01);
        rd(das_pkg::SEL_INT, 16'h8826);
        issue(das_pkg::FN_SPD_SEL, 16'h1f01);
        $display("test flags done");
    endtask : t_flags

    initial begin
        err_total = 0;
        num_checks = 0;
        arst_n = 1'b0;
        go = 1'b0;
        go_code = 5'h00;
        go_acc = 16'h0000;
        spd_evt = '0;
        ecc_evt = '0;
        nib_par_err = 1'b0;
        xfer_count = 16'hbeef;
        supply_pins = 2'b10;
        for (int i = 0; i < das_pkg::SPINDLES; i++) begin
            cb[i] = 8'h00;
        end
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_parcels();
        t_err();
        t_mask();
        t_clear();
        t_ecc();
        t_flags();
        final_report();
    end
endmodule : das_status_select_bench
